// ==== core/rtc_irq_pkg.sv ====
// constants, bus carrier and register layout of the rtc interrupt and
// rate logic; assumes an 8-bit register port with a 7-bit byte address.
//
// Overview of operation
// - summary flag is set while any event flag meets its enable.
// - interrupt output is low exactly while the summary flag is set.
// - periodic flag sets on each rising edge of the selected divider tap.
// - alarm flag sets on alarm match; interrupt only with alarm enable.
// - update-done flag sets after each update; raises interrupt if enabled.
// - event flags set regardless of enables, so software may poll them.
// - reading the flag register or reset clears all flags and summary.
// - flag value is held during read; events arriving then are kept.
// - low four flag register bits read zero and ignore writes.
// - enabling with a flag already set asserts the interrupt at once.
// - battery status top bit shows battery good, read only, no reset.
// - lower seven battery status bits read zero and ignore writes.
// - 114 bytes of plain memory, always readable and writable.
// - oscillator field: 010 runs, 11x holds chain reset, else stopped.
// - thirteen of fifteen divider taps feed a sixteen-way selector.
// - rate code 0 off, 3..15 double from 122us, 1 and 2 repeat 8, 9.
// - periods span 122us to 500ms, square wave 8.192kHz down to 2Hz.
// - square pin and periodic interrupt share rate, separate enables.
// - square pin is held low while the square enable is clear.
// - setting the hold bit or reset clears the update interrupt enable.
// - reset clears all interrupt enables and square enable, not the rate.

package rtc_irq_pkg;

   // ==========================================================
   // bus widths and carrier
   localparam int ADDR_W = 7;
   localparam int DATA_W = 8;

   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
      logic wr;
      logic rd;
   } bus_req_t;

   // ==========================================================
   // register offsets
   localparam logic [ADDR_W-1:0] REG_RATE_OFS = 7'h0A;
   localparam logic [ADDR_W-1:0] REG_ENABLE_OFS = 7'h0B;
   localparam logic [ADDR_W-1:0] REG_FLAG_OFS = 7'h0C;
   localparam logic [ADDR_W-1:0] REG_BATT_OFS = 7'h0D;
   localparam logic [ADDR_W-1:0] RAM_BASE = 7'h0E;
   localparam int RAM_BYTES = 114;

   // ==========================================================
   // field positions
   localparam int RATE_LSB = 0;
   localparam int RATE_W = 4;
   localparam int OSC_LSB = 4;
   localparam int OSC_W = 3;
   localparam int SET_BIT = 7;
   localparam int PIE_BIT = 6;
   localparam int AIE_BIT = 5;
   localparam int UIE_BIT = 4;
   localparam int SQUARE_OUT_ENABLE_BIT = 3;
   localparam int MISC_W = 3;
   localparam int SUM_BIT = 7;
   localparam int PF_BIT = 6;
   localparam int AF_BIT = 5;
   localparam int UF_BIT = 4;
   localparam int BATT_BIT = 7;

   // ==========================================================
   // encodings and reset values
   localparam logic [OSC_W-1:0] OSC_RUN = 3'h2;
   localparam logic [1:0] OSC_HOLD_TOP = 2'h3;
   localparam logic [2:0] ENABLE_RST = 3'h0;
   localparam logic [2:0] FLAG_RST = 3'h0;
   localparam logic SQUARE_OUT_ENABLE_RST = 1'h0;
   localparam logic IRQ_N_RST = 1'h1;
   localparam int DIV_STAGES = 15;
   localparam int SYNC_STAGES = 3;

endpackage

// ==== core/rtc_irq_rate.sv ====
// interrupt flags, battery status, oscillator control, rate selection and
// general memory of the rtc; the 32.768 kHz oscillator and battery level
// arrive as pins, alarm match and update done as one-cycle clk_i pulses.
// assumes a host that never raises both strobes in one cycle, and a
// reset that may rise at any time and falls away from a clock edge.
`timescale 1ns/1ps

module rtc_irq_rate
   import rtc_irq_pkg::*;
#(
   parameter int RAM_DEPTH = RAM_BYTES
) (
   input wire logic clk_i,
   input wire logic sys_rst_i,
   input wire bus_req_t bus_i,
   input wire logic osc_pin_i,
   input wire logic battery_good_pin_i,
   input wire logic alarm_match_i,
   input wire logic update_done_i,
   output logic [DATA_W-1:0] rd_data_o,
   output logic irq_n_o,
   output logic square_out_pin_o,
   output logic osc_running_o
);

   // ==========================================================
   // pin synchronisers
   logic [SYNC_STAGES-1:0] osc_sync;
   logic [SYNC_STAGES-1:0] batt_sync;
   logic osc_level;
   logic battery_good_flag;
   logic next_osc_level;
   logic next_battery_good_flag;
   logic [SYNC_STAGES-1:0] next_osc_sync;
   logic [SYNC_STAGES-1:0] next_batt_sync;

   // a level counts once the second and third stage agree; the first
   // stage may be metastable, so only the second stage reads it
   always_comb begin
      next_osc_sync = {osc_sync[SYNC_STAGES-2:0], osc_pin_i};
      next_batt_sync = {batt_sync[SYNC_STAGES-2:0], battery_good_pin_i};
      next_osc_level = osc_level;
      next_battery_good_flag = battery_good_flag;
      if (osc_sync[1] == osc_sync[2]) begin
         next_osc_level = osc_sync[2];
      end
      if (batt_sync[1] == batt_sync[2]) begin
         next_battery_good_flag = batt_sync[2];
      end
   end

   // battery level is not touched by reset, so no reset here
   always_ff @(posedge clk_i) begin
      batt_sync <= next_batt_sync;
      battery_good_flag <= next_battery_good_flag;
   end

   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         osc_sync <= '0;
         osc_level <= 1'b0;
      end else begin
         osc_sync <= next_osc_sync;
         osc_level <= next_osc_level;
      end
   end

   // ==========================================================
   // bus decode
   logic hit_rate;
   logic hit_enable;
   logic hit_flag;
   logic hit_batt;
   logic hit_ram;
   logic [ADDR_W-1:0] ram_idx;

   // memory window runs from its base to the top of the address space
   always_comb begin
      hit_rate = (bus_i.addr == REG_RATE_OFS);
      hit_enable = (bus_i.addr == REG_ENABLE_OFS);
      hit_flag = (bus_i.addr == REG_FLAG_OFS);
      hit_batt = (bus_i.addr == REG_BATT_OFS);
      hit_ram = (bus_i.addr >= RAM_BASE) &&
                (int'(bus_i.addr) < int'(RAM_BASE) + RAM_DEPTH);
      ram_idx = bus_i.addr - RAM_BASE;
   end

   // ==========================================================
   // control bits that reset leaves alone
   logic [RATE_W-1:0] rate_sel;
   logic [OSC_W-1:0] osc_ctrl;
   logic clock_hold;
   logic [MISC_W-1:0] misc_ctrl;
   logic [RATE_W-1:0] next_rate_sel;
   logic [OSC_W-1:0] next_osc_ctrl;
   logic next_clock_hold;
   logic [MISC_W-1:0] next_misc_ctrl;

   // rate, oscillator and hold bits take plain writes
   always_comb begin
      next_rate_sel = rate_sel;
      next_osc_ctrl = osc_ctrl;
      next_clock_hold = clock_hold;
      next_misc_ctrl = misc_ctrl;
      // rate register: oscillator field above the rate code
      if (bus_i.wr && hit_rate) begin
         next_rate_sel = bus_i.wdata[RATE_LSB +: RATE_W];
         next_osc_ctrl = bus_i.wdata[OSC_LSB +: OSC_W];
      end
      // enable register: hold bit and plain storage bits
      if (bus_i.wr && hit_enable) begin
         next_clock_hold = bus_i.wdata[SET_BIT];
         next_misc_ctrl = bus_i.wdata[MISC_W-1:0];
      end
   end

   // rate select survives reset; so do the oscillator field, the hold
   // bit and the plain bits, which software must write after power-up
   always_ff @(posedge clk_i) begin
      rate_sel <= next_rate_sel;
      osc_ctrl <= next_osc_ctrl;
      clock_hold <= next_clock_hold;
      misc_ctrl <= next_misc_ctrl;
   end

   // ==========================================================
   // interrupt and square enables
   logic periodic_int_enable;
   logic alarm_int_enable;
   logic update_int_enable;
   logic square_out_enable;
   logic next_periodic_int_enable;
   logic next_alarm_int_enable;
   logic next_update_int_enable;
   logic next_square_out_enable;

   always_comb begin
      next_periodic_int_enable = periodic_int_enable;
      next_alarm_int_enable = alarm_int_enable;
      next_update_int_enable = update_int_enable;
      next_square_out_enable = square_out_enable;
      if (bus_i.wr && hit_enable) begin
         next_periodic_int_enable = bus_i.wdata[PIE_BIT];
         next_alarm_int_enable = bus_i.wdata[AIE_BIT];
         next_update_int_enable = bus_i.wdata[UIE_BIT];
         next_square_out_enable = bus_i.wdata[SQUARE_OUT_ENABLE_BIT];
         // raising the hold bit drops the update enable at once
         if (bus_i.wdata[SET_BIT]) begin
            next_update_int_enable = 1'b0;
         end
      end
   end

   // reset clears every enable
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         periodic_int_enable <= ENABLE_RST[2];
         alarm_int_enable <= ENABLE_RST[1];
         update_int_enable <= ENABLE_RST[0];
         square_out_enable <= SQUARE_OUT_ENABLE_RST;
      end else begin
         periodic_int_enable <= next_periodic_int_enable;
         alarm_int_enable <= next_alarm_int_enable;
         update_int_enable <= next_update_int_enable;
         square_out_enable <= next_square_out_enable;
      end
   end

   // ==========================================================
   // oscillator gate and fifteen-stage divider
   logic osc_prev;
   logic [DIV_STAGES-1:0] div_chain;
   logic chain_run;
   logic chain_hold;
   logic osc_on;
   logic osc_tick;
   logic next_osc_prev;
   logic [DIV_STAGES-1:0] next_div_chain;
   logic next_osc_running;

   // 010 runs, 11x holds the chain cleared, anything else stops
   always_comb begin
      chain_run = (osc_ctrl == OSC_RUN);
      chain_hold = (osc_ctrl[2:1] == OSC_HOLD_TOP);
      osc_on = chain_run || chain_hold;
      next_osc_running = osc_on;
      osc_tick = osc_on && osc_level && !osc_prev;
      next_osc_prev = osc_level;
      next_div_chain = div_chain;
      if (chain_hold) begin
         next_div_chain = '0;
      end else if (chain_run && osc_tick) begin
         next_div_chain = div_chain + 1'b1;
      end
   end

   // a stopped chain keeps its count, so a restart resumes mid-period
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         osc_prev <= 1'b0;
         div_chain <= '0;
         osc_running_o <= 1'b0;
      end else begin
         osc_prev <= next_osc_prev;
         div_chain <= next_div_chain;
         osc_running_o <= next_osc_running;
      end
   end

   // ==========================================================
   // rate selector
   // tap n of the chain has period 2^(n+1) oscillator cycles; code 3
   // (122.070 us, 8.192 kHz) picks tap 1, code 15 (500 ms, 2 Hz) tap 13
   logic tap_level;
   logic tap_prev;
   logic periodic_event;
   logic next_tap_prev;
   logic next_square_out_pin;

   // sixteen-way selector over thirteen taps; code 0 gives a steady low,
   // codes 1 and 2 (3.90625 ms, 7.8125 ms) repeat the taps of 8 and 9
   always_comb begin
      case (rate_sel)
         4'h0: tap_level = 1'b0;
         4'h1: tap_level = div_chain[6];
         4'h2: tap_level = div_chain[7];
         4'h3: tap_level = div_chain[1];
         4'h4: tap_level = div_chain[2];
         4'h5: tap_level = div_chain[3];
         4'h6: tap_level = div_chain[4];
         4'h7: tap_level = div_chain[5];
         4'h8: tap_level = div_chain[6];
         4'h9: tap_level = div_chain[7];
         4'hA: tap_level = div_chain[8];
         4'hB: tap_level = div_chain[9];
         4'hC: tap_level = div_chain[10];
         4'hD: tap_level = div_chain[11];
         4'hE: tap_level = div_chain[12];
         4'hF: tap_level = div_chain[13];
         default: tap_level = 1'b0;
      endcase
   end

   // edge detect and square pin on the selected tap
   always_comb begin
      periodic_event = tap_level && !tap_prev;
      next_tap_prev = tap_level;
      // same tap for pin and flag, each with its own enable
      next_square_out_pin = square_out_enable && tap_level;
   end

   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         tap_prev <= 1'b0;
         square_out_pin_o <= 1'b0;
      end else begin
         tap_prev <= next_tap_prev;
         square_out_pin_o <= next_square_out_pin;
      end
   end

   // ==========================================================
   // event flags, summary and interrupt pin
   logic periodic_flag;
   logic alarm_flag;
   logic update_done_flag;
   logic int_summary_flag;
   logic next_periodic_flag;
   logic next_alarm_flag;
   logic next_update_done_flag;
   logic next_int_summary_flag;
   logic flag_read;
   logic next_irq_n;

   always_comb begin
      flag_read = bus_i.rd && hit_flag;
      next_periodic_flag = periodic_flag;
      next_alarm_flag = alarm_flag;
      next_update_done_flag = update_done_flag;
      // clear at the end of the read strobe
      if (flag_read) begin
         next_periodic_flag = 1'b0;
         next_alarm_flag = 1'b0;
         next_update_done_flag = 1'b0;
      end
      // events set whatever the enables; set wins over clear
      if (periodic_event) begin
         next_periodic_flag = 1'b1;
      end
      if (alarm_match_i) begin
         next_alarm_flag = 1'b1;
      end
      if (update_done_i) begin
         next_update_done_flag = 1'b1;
      end
      // built from next enables too, so enabling a set flag acts at once
      next_int_summary_flag =
         (next_periodic_flag && next_periodic_int_enable) ||
         (next_alarm_flag && next_alarm_int_enable) ||
         (next_update_done_flag && next_update_int_enable);
      next_irq_n = !next_int_summary_flag;
   end

   // flags and pin share one edge, so the pin never lags the summary
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         periodic_flag <= FLAG_RST[2];
         alarm_flag <= FLAG_RST[1];
         update_done_flag <= FLAG_RST[0];
         int_summary_flag <= 1'b0;
         irq_n_o <= IRQ_N_RST;
      end else begin
         periodic_flag <= next_periodic_flag;
         alarm_flag <= next_alarm_flag;
         update_done_flag <= next_update_done_flag;
         int_summary_flag <= next_int_summary_flag;
         irq_n_o <= next_irq_n;
      end
   end

   // ==========================================================
   // general memory, battery backed so never reset
   logic [DATA_W-1:0] ram [RAM_DEPTH];

   // no reset: contents must outlive a reset of the logic
   always_ff @(posedge clk_i) begin
      if (bus_i.wr && hit_ram) begin
         ram[ram_idx] <= bus_i.wdata;
      end
   end

   // ==========================================================
   // read data, valid only in the cycle after the strobe
   logic [DATA_W-1:0] next_rd_data;

   // idle cycles and unmapped addresses read back as zero
   always_comb begin
      next_rd_data = '0;
      if (bus_i.rd) begin
         if (hit_rate) begin
            next_rd_data[RATE_LSB +: RATE_W] = rate_sel;
            next_rd_data[OSC_LSB +: OSC_W] = osc_ctrl;
         end else if (hit_enable) begin
            next_rd_data[SET_BIT] = clock_hold;
            next_rd_data[PIE_BIT] = periodic_int_enable;
            next_rd_data[AIE_BIT] = alarm_int_enable;
            next_rd_data[UIE_BIT] = update_int_enable;
            next_rd_data[SQUARE_OUT_ENABLE_BIT] = square_out_enable;
            next_rd_data[MISC_W-1:0] = misc_ctrl;
         end else if (hit_flag) begin
            // value before the clear is captured; low bits stay zero
            next_rd_data[SUM_BIT] = int_summary_flag;
            next_rd_data[PF_BIT] = periodic_flag;
            next_rd_data[AF_BIT] = alarm_flag;
            next_rd_data[UF_BIT] = update_done_flag;
         end else if (hit_batt) begin
            next_rd_data[BATT_BIT] = battery_good_flag;
         end else if (hit_ram) begin
            next_rd_data = ram[ram_idx];
         end
      end
   end

   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         rd_data_o <= '0;
      end else begin
         rd_data_o <= next_rd_data;
      end
   end

endmodule

// ==== testbench/rtc_host.sv ====
// host model: drives the register port of the rtc block
// assumes callers resume just after a rising edge of clk_i
`timescale 1ns/1ps
module rtc_host
   import rtc_irq_pkg::*;
(
   input wire logic clk_i,
   input wire logic [DATA_W-1:0] rd_data_i,
   output bus_req_t bus_o
);
   // ====================================================
   // bus cycles
   initial begin
      bus_o = '0;
   end
   // one-cycle write, address and data scrambled once released
   task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
      bus_o <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge clk_i);
      bus_o <= '{addr: ~a, wdata: ~d, wr: 1'b0, rd: 1'b0};
      #1;
   endtask
   // one-cycle read, data taken in the following cycle only
   task automatic rd(input logic [ADDR_W-1:0] a, output logic [7:0] d);
      bus_o <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      @(posedge clk_i);
      bus_o <= '{addr: ~a, wdata: 8'hFF, wr: 1'b0, rd: 1'b0};
      #1;
      d = rd_data_i;
   endtask
endmodule

// ==== testbench/rtc_irq_rate_asserts.sv ====
// checker for the rtc interrupt and rate block, seeing only its ports
// assumes enable and rate registers change only through bus_i writes
`timescale 1ns/1ps
module rtc_irq_rate_asserts
   import rtc_irq_pkg::*;
(
   input wire logic clk_i,
   input wire logic sys_rst_i,
   input wire bus_req_t bus_i,
   input wire logic alarm_match_i,
   input wire logic update_done_i,
   input wire logic [DATA_W-1:0] rd_data_o,
   input wire logic irq_n_o,
   input wire logic square_out_pin_o,
   input wire logic osc_running_o
);
   // ====================================================
   // shadows of the enable and rate registers
   logic [3:0] en;
   logic [6:0] rate;
   logic rate_ok;
   logic en_wr;
   logic rate_wr;
   logic flag_rd;
   logic osc_exp;
   // decoded bus strobes
   assign en_wr = bus_i.wr && bus_i.addr == REG_ENABLE_OFS;
   assign rate_wr = bus_i.wr && bus_i.addr == REG_RATE_OFS;
   assign flag_rd = bus_i.rd && bus_i.addr == REG_FLAG_OFS;
   assign osc_exp = rate[6:4] == OSC_RUN || rate[6:5] == OSC_HOLD_TOP;
   // shadow update, hold bit knocks out update enable
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         en <= 4'h0;
         rate_ok <= 1'b0;
      end else begin
         if (en_wr) begin
            en <= {bus_i.wdata[6:5], bus_i.wdata[4] & ~bus_i.wdata[7],
               bus_i.wdata[3]};
         end
         if (rate_wr) begin
            rate <= bus_i.wdata[6:0];
            rate_ok <= 1'b1;
         end
      end
   end
   // ====================================================
   // properties
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (sys_rst_i);
   a_flag_low_zero: assert property ($past(flag_rd) |->
      rd_data_o[3:0] == 4'h0) else $error("flag low bits not zero");
   a_batt_low_zero: assert property (
      $past(bus_i.rd && bus_i.addr == REG_BATT_OFS) |->
      rd_data_o[6:0] == 7'h00) else $error("battery low bits not zero");
   a_sum_pin_match: assert property ($past(flag_rd) |->
      rd_data_o[SUM_BIT] == !$past(irq_n_o)) else $error("summary vs pin");
   a_sum_from_flags: assert property ($past(flag_rd) |->
      rd_data_o[SUM_BIT] == |(rd_data_o[6:4] & $past(en[3:1])))
      else $error("summary not flags and enables");
   a_alarm_irq_low: assert property (
      alarm_match_i && en[2] && !en_wr |=> !irq_n_o)
      else $error("alarm did not assert interrupt");
   a_update_irq_low: assert property (
      update_done_i && en[1] && !en_wr |=> !irq_n_o)
      else $error("update did not assert interrupt");
   a_irq_masked: assert property (en[3:1] == 3'h0 |-> irq_n_o)
      else $error("interrupt with all enables clear");
   a_square_off: assert property (
      !en[0] && !$past(en[0]) |-> !square_out_pin_o)
      else $error("square pin high while disabled");
   a_osc_field: assert property (
      rate_ok && !$past(rate_wr) |-> osc_running_o == osc_exp)
      else $error("oscillator state wrong");
   a_read_clears: assert property (
      $past(flag_rd && !alarm_match_i && !update_done_i) && rate_ok &&
      rate[3:0] == 4'h0 && !$past(rate_wr) |-> irq_n_o)
      else $error("flag read did not release interrupt");
endmodule

bind rtc_irq_rate rtc_irq_rate_asserts chk_i (.clk_i, .sys_rst_i, .bus_i,
   .alarm_match_i, .update_done_i, .rd_data_o, .irq_n_o, .square_out_pin_o,
   .osc_running_o);

// ==== testbench/rtc_irq_rate_test.sv ====
// self-checking bench for the rtc block with host model and event pulses
// assumes the checker is bound from its own file
`timescale 1ns/1ps
module rtc_irq_rate_test;
   import rtc_irq_pkg::*;
   logic clk_i = 1'b0;
   logic sys_rst_i = 1'b1;
   logic osc_pin_i = 1'b0;
   logic battery_good_pin_i = 1'b1;
   logic alarm_match_i = 1'b0;
   logic update_done_i = 1'b0;
   bus_req_t bus;
   logic [DATA_W-1:0] rd_data;
   logic irq_n;
   logic sq;
   logic osc_run;
   int err_count = 0;
   int total_checks = 0;
   int cycles = 0;
   logic [31:0] seed = 32'h4a8c;
   logic [7:0] d;
   // ====================================================
   // clocks, timeout and instances
   initial begin
      forever #2.5 clk_i = ~clk_i;
   end
   // fast oscillator: ten clk cycles a period
   initial begin
      #2;
      forever #25 osc_pin_i = ~osc_pin_i;
   end
   always @(posedge clk_i) begin
      cycles <= cycles + 1;
      if (cycles == 80000) begin
         err_count++;
         test_done();
      end
   end
   rtc_irq_rate dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .bus_i(bus),
      .osc_pin_i(osc_pin_i), .battery_good_pin_i(battery_good_pin_i),
      .alarm_match_i(alarm_match_i), .update_done_i(update_done_i),
      .rd_data_o(rd_data), .irq_n_o(irq_n), .square_out_pin_o(sq),
      .osc_running_o(osc_run));
   rtc_host host (.clk_i(clk_i), .rd_data_i(rd_data), .bus_o(bus));
   // ====================================================
   // helpers
   task automatic tick(input int n);
      repeat (n) @(posedge clk_i);
      #1;
   endtask
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      total_checks++;
      if (got !== exp) begin
         err_count++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   function automatic logic [31:0] lfsr(input logic [31:0] x);
      return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction
   // tap period in clk cycles, codes 1 and 2 alias 8 and 9
   function automatic int exp_period(input int c);
      return 10 << (((c < 3) ? c + 7 : c) - 1);
   endfunction
   function automatic logic exp_osc(input logic [2:0] v);
      return v == OSC_RUN || v[2:1] == OSC_HOLD_TOP;
   endfunction
   task automatic pulse(input logic a, input logic u);
      alarm_match_i <= a;
      update_done_i <= u;
      tick(1);
      alarm_match_i <= 1'b0;
      update_done_i <= 1'b0;
   endtask
   // ticks until the next square rising edge, lim if none
   task automatic rise(input int lim, output int n);
      logic p;
      p = sq;
      for (n = 1; n < lim; n++) begin
         tick(1);
         if (p === 1'b0 && sq === 1'b1) break;
         p = sq;
      end
   endtask
   task automatic test_done();
      $display("checks %0d mismatches %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   // ====================================================
   // main sequence
   initial begin
      int c;
      int n;
      logic [6:0] a;
      tick(16);
      sys_rst_i <= 1'b0;
      tick(1);
      host.wr(REG_RATE_OFS, 8'h20);
      host.wr(REG_ENABLE_OFS, 8'h00);
      host.wr(REG_BATT_OFS, 8'hFF);
      host.rd(REG_BATT_OFS, d);
      chk(d, 8'h80);
      battery_good_pin_i <= 1'b0;
      tick(8);
      host.rd(REG_BATT_OFS, d);
      chk(d, 8'h00);
      battery_good_pin_i <= 1'b1;
      $display("test battery done");
      pulse(1'b1, 1'b1);
      chk({7'h00, irq_n}, 8'h01);
      host.rd(REG_FLAG_OFS, d);
      chk(d, 8'h30);
      host.wr(REG_FLAG_OFS, 8'hFF);
      host.rd(REG_FLAG_OFS, d);
      chk(d, 8'h00);
      pulse(1'b1, 1'b0);
      host.wr(REG_ENABLE_OFS, 8'h20);
      chk({7'h00, irq_n}, 8'h00);
      host.rd(REG_FLAG_OFS, d);
      chk(d, 8'hA0);
      chk({7'h00, irq_n}, 8'h01);
      pulse(1'b1, 1'b0);
      chk({7'h00, irq_n}, 8'h00);
      host.rd(REG_FLAG_OFS, d);
      chk(d, 8'hA0);
      host.wr(REG_ENABLE_OFS, 8'h10);
      update_done_i <= 1'b1;
      host.rd(REG_FLAG_OFS, d);
      update_done_i <= 1'b0;
      chk(d, 8'h00);
      chk({7'h00, irq_n}, 8'h00);
      host.wr(REG_ENABLE_OFS, 8'h90);
      chk({7'h00, irq_n}, 8'h01);
      host.rd(REG_FLAG_OFS, d);
      chk(d, 8'h10);
      $display("test flags done");
      host.wr(REG_ENABLE_OFS, 8'h08);
      for (c = 1; c <= 10; c++) begin
         host.wr(REG_RATE_OFS, {4'h2, c[3:0]});
         // a rate change may leave a short pulse: skip two edges first
         rise(2 * exp_period(c) + 20, n);
         rise(2 * exp_period(c) + 20, n);
         rise(2 * exp_period(c) + 20, n);
         chk({7'h00, n == exp_period(c)}, 8'h01);
      end
      host.wr(REG_RATE_OFS, 8'h23);
      host.wr(REG_ENABLE_OFS, 8'h00);
      tick(100);
      host.rd(REG_FLAG_OFS, d);
      chk(d, 8'h40);
      chk({7'h00, sq}, 8'h00);
      tick(60);
      host.wr(REG_ENABLE_OFS, 8'h40);
      chk({7'h00, irq_n}, 8'h00);
      host.rd(REG_FLAG_OFS, d);
      chk(d, 8'hC0);
      host.wr(REG_RATE_OFS, 8'h20);
      tick(300);
      host.rd(REG_FLAG_OFS, d);
      tick(300);
      host.rd(REG_FLAG_OFS, d);
      chk(d, 8'h00);
      $display("test rates done");
      for (c = 0; c < 8; c++) begin
         host.wr(REG_RATE_OFS, {1'b0, c[2:0], 4'h3});
         tick(2);
         chk({7'h00, osc_run}, {7'h00, exp_osc(c[2:0])});
      end
      host.wr(REG_ENABLE_OFS, 8'h08);
      for (c = 0; c < 3; c++) begin
         host.wr(REG_RATE_OFS, (c == 0) ? 8'h03 : (c == 1) ? 8'h63 : 8'h23);
         rise(100, n);
         chk({7'h00, n < 100}, {7'h00, c == 2});
      end
      $display("test oscillator done");
      for (c = 0; c < 8; c++) begin
         seed = lfsr(seed);
         a = (seed[6:0] < RAM_BASE) ? seed[6:0] + RAM_BASE : seed[6:0];
         update_done_i <= seed[16];
         host.wr(a, seed[15:8]);
         update_done_i <= 1'b0;
         host.rd(a, d);
         chk(d, seed[15:8]);
      end
      host.rd(7'h05, d);
      chk(d, 8'h00);
      $display("test memory done");
      host.wr(REG_ENABLE_OFS, 8'h7F);
      host.wr(REG_RATE_OFS, 8'h25);
      sys_rst_i <= 1'b1;
      tick(2);
      sys_rst_i <= 1'b0;
      tick(1);
      host.rd(REG_ENABLE_OFS, d);
      chk(d, 8'h07);
      host.rd(REG_RATE_OFS, d);
      chk(d & 8'h7F, 8'h25);
      host.rd(REG_BATT_OFS, d);
      chk(d, 8'h80);
      $display("test reset done");
      test_done();
   end
endmodule
